// >>> logic/pscl_top.sv
// power-saving control: discharge wake detector, sleep regulator mode, doze
// assumes AXI4-Lite master with one write and one read in flight at most
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
module pscl_top
	import pscl_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  rstn_in,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                  s_axi_awvalid_in,
	output logic                       s_axi_awready_out,
	input  wire logic [31:0]           s_axi_wdata_in,
	input  wire logic [3:0]            s_axi_wstrb_in,
	input  wire logic                  s_axi_wvalid_in,
	output logic                       s_axi_wready_out,
	output logic [1:0]                 s_axi_bresp_out,
	output logic                       s_axi_bvalid_out,
	input  wire logic                  s_axi_bready_in,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                  s_axi_arvalid_in,
	output logic                       s_axi_arready_out,
	output logic [31:0]                s_axi_rdata_out,
	output logic [1:0]                 s_axi_rresp_out,
	output logic                       s_axi_rvalid_out,
	input  wire logic                  s_axi_rready_in,
	input  wire logic                  sleep_cmd_in,
	input  wire logic                  deep_sleep_sel_in,
	input  wire logic                  idle_in,
	input  wire logic                  wake_event_in,
	input  wire logic                  irq_in,
	input  wire logic                  wake_sense_pin_in,
	input  wire logic                  low_voltage_regulator_fuse_in,
	output logic                       discharge_sink_out,
	output logic                       discharge_wake_irq_flag_out,
	output logic                       main_reg_full_out,
	output logic                       main_reg_standby_out,
	output logic                       lowv_reg_enable_out,
	output logic                       lowv_reg_supply_out,
	output logic                       core_ready_out,
	output logic                       cpu_clk_en_out
);

	typedef struct packed {
		logic                  aw_have;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic                  w_have;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic                  wk_en;
		logic                  wk_idle_stop;
		logic                  wk_sink;
		logic                  lvr_en;
		logic                  pm_sel;
		logic                  rec_on_irq;
		logic [2:0]            doze_ratio;
		logic                  doze_en;
		logic                  wake_flag;
		pscl_pwr_e             pwr;
		pscl_reg_e             sleep_mode;
		logic [11:0]           cnt;
		logic                  detector_on;
		logic                  sink_en;
		logic                  hv_full;
		logic                  hv_standby;
		logic                  lv_enable;
		logic                  lv_supply;
		logic                  core_ready;
	} pscl_state_s;

	pscl_state_s s_r;
	pscl_state_s s_nxt;
	pscl_doze_if dz ();
	logic        trip;
	logic        wr_fire;

	pscl_doze_div u_doze (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.dz      (dz)
	);

	function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] a);
		return a == ADDR_WAKE_CTRL || a == ADDR_RESET_CTRL || a == ADDR_CLK_DIV
			|| a == ADDR_STATUS;
	endfunction

	// low-voltage wins only with fuse clear, enable set and mode bit clear
	function automatic pscl_reg_e mode_sel(input logic fuse, input logic lvr, input logic pm);
		if (pm) begin
			return REG_FULL;
		end else if (!fuse && lvr) begin
			return REG_LOWV;
		end else begin
			return REG_STANDBY;
		end
	endfunction

	function automatic logic [11:0] wake_lat(input pscl_reg_e m);
		case (m)
			REG_FULL:    return 12'(FAST_WAKE_CYC);
			REG_STANDBY: return 12'(STBY_WAKE_CYC);
			REG_LOWV:    return 12'(LOWV_WAKE_CYC);
			default:     return 12'(DEEP_WAKE_CYC);
		endcase
	endfunction

	function automatic logic [31:0] rd_word(input pscl_state_s s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			ADDR_WAKE_CTRL: begin
				v[WK_EN_BIT]   = s.wk_en;
				v[WK_IDLE_BIT] = s.wk_idle_stop;
				v[WK_SINK_BIT] = s.wk_sink;
			end
			ADDR_RESET_CTRL: begin
				v[LVR_EN_BIT] = s.lvr_en;
				v[PM_SEL_BIT] = s.pm_sel;
			end
			ADDR_CLK_DIV: begin
				v[RECOVER_BIT]              = s.rec_on_irq;
				v[RATIO_LSB+2:RATIO_LSB]    = s.doze_ratio;
				v[DOZE_EN_BIT]              = s.doze_en;
			end
			ADDR_STATUS: begin
				v[ST_FLAG_BIT]              = s.wake_flag;
				v[ST_MODE_LSB+1:ST_MODE_LSB] = s.sleep_mode;
				v[ST_DOZE_BIT]              = s.doze_en & s.core_ready;
				v[ST_READY_BIT]             = s.core_ready;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	assign trip    = s_r.detector_on & ~wake_sense_pin_in;
	assign wr_fire = s_r.aw_have & s_r.w_have & ~s_r.bvalid;

	assign dz.doze_en = s_r.doze_en;
	assign dz.ratio   = s_r.doze_ratio;
	assign dz.rec_on_irq = s_r.rec_on_irq;
	assign dz.irq     = irq_in;
	assign dz.run     = s_r.pwr == PWR_RUN;

	always_comb begin
		s_nxt = s_r;
		// write channel: address and data taken in either order
		if (s_axi_awvalid_in && s_r.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_r.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = s_axi_wdata_in;
			s_nxt.w_strb = s_axi_wstrb_in;
		end
		if (s_r.bvalid && s_axi_bready_in) begin
			s_nxt.bvalid = 1'b0;
		end
		// hardware clear of doze first so a software write in the same cycle wins
		if (dz.recover) begin
			s_nxt.doze_en = 1'b0;
		end
		if (wr_fire) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = addr_ok(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			// every field sits in byte lane 1; lane 0 holds only the status flag
			if (s_r.aw_addr == ADDR_WAKE_CTRL && s_r.w_strb[1]) begin
				s_nxt.wk_en        = s_r.w_data[WK_EN_BIT];
				s_nxt.wk_idle_stop = s_r.w_data[WK_IDLE_BIT];
				s_nxt.wk_sink      = s_r.w_data[WK_SINK_BIT];
			end
			if (s_r.aw_addr == ADDR_RESET_CTRL && s_r.w_strb[1]) begin
				s_nxt.lvr_en = s_r.w_data[LVR_EN_BIT];
				s_nxt.pm_sel = s_r.w_data[PM_SEL_BIT];
			end
			if (s_r.aw_addr == ADDR_CLK_DIV && s_r.w_strb[1]) begin
				s_nxt.rec_on_irq = s_r.w_data[RECOVER_BIT];
				s_nxt.doze_ratio = s_r.w_data[RATIO_LSB+2:RATIO_LSB];
				s_nxt.doze_en    = s_r.w_data[DOZE_EN_BIT];
			end
			if (s_r.aw_addr == ADDR_STATUS && s_r.w_strb[0] && s_r.w_data[ST_FLAG_BIT]) begin
				s_nxt.wake_flag = 1'b0;
			end
		end
		s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
		s_nxt.wready  = ~s_nxt.w_have & ~s_nxt.bvalid;
		// read channel: one cycle from address to data
		if (s_r.rvalid && s_axi_rready_in) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd_word(s_r, s_axi_araddr_in);
			s_nxt.rresp  = addr_ok(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
		end
		s_nxt.arready = ~s_nxt.rvalid;
		// power sequence
		case (s_r.pwr)
			PWR_RUN: begin
				if (sleep_cmd_in) begin
					s_nxt.pwr        = deep_sleep_sel_in ? PWR_DEEP : PWR_SLEEP;
					s_nxt.sleep_mode = deep_sleep_sel_in ? REG_OFF
						: mode_sel(low_voltage_regulator_fuse_in, s_r.lvr_en, s_r.pm_sel);
				end
			end
			PWR_SLEEP: begin
				if (trip || wake_event_in) begin
					s_nxt.pwr = PWR_WAKE;
					s_nxt.cnt = wake_lat(s_r.sleep_mode) - 12'h001;
				end
			end
			PWR_DEEP: begin
				if (wake_event_in) begin
					s_nxt.pwr = PWR_WAKE;
					s_nxt.cnt = wake_lat(REG_OFF) - 12'h001;
				end
			end
			PWR_WAKE: begin
				if (s_r.cnt == 12'h000) begin
					s_nxt.pwr = PWR_RUN;
				end else begin
					s_nxt.cnt = s_r.cnt - 12'h001;
				end
			end
			default: s_nxt.pwr = PWR_RUN;
		endcase
		// set wins over the software clear above
		if (s_r.pwr == PWR_SLEEP && trip) begin
			s_nxt.wake_flag = 1'b1;
		end
		s_nxt.detector_on = s_nxt.wk_en & ~(s_nxt.wk_idle_stop & idle_in);
		s_nxt.sink_en     = s_nxt.detector_on & s_nxt.wk_sink;
		// regulator drive from the coming state; wake ramps the main regulator back
		s_nxt.lv_enable  = ~low_voltage_regulator_fuse_in & s_nxt.lvr_en;
		s_nxt.hv_full    = 1'b1;
		s_nxt.hv_standby = 1'b0;
		s_nxt.lv_supply  = 1'b0;
		if (s_nxt.pwr == PWR_SLEEP) begin
			s_nxt.hv_full    = s_nxt.sleep_mode == REG_FULL;
			s_nxt.hv_standby = s_nxt.sleep_mode == REG_STANDBY;
			s_nxt.lv_supply  = s_nxt.sleep_mode == REG_LOWV;
			s_nxt.lv_enable  = s_nxt.lv_enable & (s_nxt.sleep_mode == REG_LOWV);
		end else if (s_nxt.pwr == PWR_DEEP) begin
			s_nxt.hv_full   = 1'b0;
			s_nxt.lv_enable = 1'b0;
		end
		s_nxt.core_ready = s_nxt.pwr == PWR_RUN;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_r            <= '0;
			s_r.doze_ratio <= RATIO_RST;
			s_r.rec_on_irq <= BIT_RST;
			s_r.awready    <= 1'b1;
			s_r.wready     <= 1'b1;
			s_r.arready    <= 1'b1;
			s_r.hv_full    <= 1'b1;
			s_r.core_ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready_out           = s_r.awready;
	assign s_axi_wready_out            = s_r.wready;
	assign s_axi_bresp_out             = s_r.bresp;
	assign s_axi_bvalid_out            = s_r.bvalid;
	assign s_axi_arready_out           = s_r.arready;
	assign s_axi_rdata_out             = s_r.rdata;
	assign s_axi_rresp_out             = s_r.rresp;
	assign s_axi_rvalid_out            = s_r.rvalid;
	assign discharge_sink_out          = s_r.sink_en;
	assign discharge_wake_irq_flag_out = s_r.wake_flag;
	assign main_reg_full_out           = s_r.hv_full;
	assign main_reg_standby_out        = s_r.hv_standby;
	assign lowv_reg_enable_out         = s_r.lv_enable;
	assign lowv_reg_supply_out         = s_r.lv_supply;
	assign core_ready_out              = s_r.core_ready;
	assign cpu_clk_en_out              = dz.cpu_en;

	// helper: cycles spent in the wake state
	logic [11:0] wake_cyc_r;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wake_cyc_r <= 12'h000;
		end else begin
			wake_cyc_r <= (s_r.pwr == PWR_WAKE) ? wake_cyc_r + 12'h001 : 12'h000;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_armed_sleep;
		s_r.pwr == PWR_SLEEP && s_r.detector_on;
	endsequence
	sequence s_pin_low;
		!wake_sense_pin_in;
	endsequence

	a_wake_pin_trip: assert property (s_armed_sleep and s_pin_low |=>
		s_r.pwr == PWR_WAKE && discharge_wake_irq_flag_out)
		else $error("detector trip did not wake with flag");
	a_ctrl_reserved_zero: assert property (s_axi_rvalid_out && $past(s_axi_arvalid_in
		&& s_axi_arready_out && s_axi_araddr_in == ADDR_WAKE_CTRL)
		|-> (s_axi_rdata_out & 32'hffff_5eff) == 32'h0000_0000)
		else $error("reserved control bits read nonzero");
	a_sink_follows_bits: assert property (discharge_sink_out |-> s_r.wk_en && s_r.wk_sink)
		else $error("sink on without enable and sink bits");
	a_idle_stop_detector: assert property (s_r.wk_idle_stop && idle_in |=> !s_r.detector_on)
		else $error("detector ran in idle with stop set");
	a_run_main_full: assert property (core_ready_out |-> main_reg_full_out
		&& !lowv_reg_supply_out)
		else $error("run without full main regulator");
	a_fast_sleep_full: assert property (s_r.pwr == PWR_SLEEP
		&& s_r.sleep_mode == REG_FULL |-> main_reg_full_out && !main_reg_standby_out)
		else $error("fast sleep lost main regulator");
	a_lowv_sleep_only: assert property (s_r.pwr == PWR_SLEEP
		&& s_r.sleep_mode == REG_LOWV |-> !main_reg_full_out && lowv_reg_supply_out)
		else $error("low voltage sleep regulators wrong");
	a_fuse_lowv_off: assert property (low_voltage_regulator_fuse_in |=> !lowv_reg_enable_out)
		else $error("low voltage regulator on with fuse set");
	a_deep_all_off: assert property (s_r.pwr == PWR_DEEP |-> !main_reg_full_out
		&& !lowv_reg_enable_out && !main_reg_standby_out)
		else $error("regulator on in deep sleep");
	a_wake_latency: assert property (s_r.pwr == PWR_WAKE && s_nxt.pwr == PWR_RUN
		|-> wake_cyc_r + 12'h001 == wake_lat(s_r.sleep_mode))
		else $error("wake latency wrong");

endmodule

// >>> logic/pscl_pkg.sv
// constants, register map and shared types of the power-saving control block
// assumes a single 100 MHz clock and an AXI4-Lite master on the register side
package pscl_pkg;

	localparam int unsigned AXI_ADDR_W = 8;

	// register byte addresses
	localparam logic [7:0] ADDR_WAKE_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_RESET_CTRL = 8'h04;
	localparam logic [7:0] ADDR_CLK_DIV    = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0c;

	// pin_discharge_wake_control fields
	localparam int unsigned WK_EN_BIT   = 15;
	localparam int unsigned WK_IDLE_BIT = 13;
	localparam int unsigned WK_SINK_BIT = 8;
	// reset_control_register fields
	localparam int unsigned LVR_EN_BIT  = 12;
	localparam int unsigned PM_SEL_BIT  = 8;
	// clock_divider_register fields
	localparam int unsigned RECOVER_BIT = 15;
	localparam int unsigned RATIO_LSB   = 12;
	localparam int unsigned DOZE_EN_BIT = 11;
	// status fields
	localparam int unsigned ST_FLAG_BIT  = 0;
	localparam int unsigned ST_MODE_LSB  = 1;
	localparam int unsigned ST_DOZE_BIT  = 3;
	localparam int unsigned ST_READY_BIT = 4;

	// reset values
	localparam logic [2:0] RATIO_RST = 3'h0;
	localparam logic       BIT_RST   = 1'b0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// wake latencies, least times, rounded up to cycles
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned FAST_WAKE_NS  = 100;
	localparam int unsigned STBY_WAKE_NS  = 500;
	localparam int unsigned LOWV_WAKE_NS  = 2000;
	localparam int unsigned DEEP_WAKE_NS  = 10000;
	localparam int unsigned FAST_WAKE_CYC = (FAST_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STBY_WAKE_CYC = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOWV_WAKE_CYC = (LOWV_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DEEP_WAKE_CYC = (DEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {REG_FULL, REG_STANDBY, REG_LOWV, REG_OFF} pscl_reg_e;
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP, PWR_WAKE} pscl_pwr_e;

endpackage

// >>> logic/pscl_doze_if.sv
// doze control between the register block and the cpu clock divider
// assumes both ends run on the same clock
interface pscl_doze_if;
	logic       doze_en;
	logic [2:0] ratio;
	logic       rec_on_irq;
	logic       irq;
	logic       run;
	logic       cpu_en;
	logic       recover;

	modport ctrl (output doze_en, output ratio, output rec_on_irq, output irq, output run,
		input cpu_en, input recover);
	modport div  (input doze_en, input ratio, input rec_on_irq, input irq, input run,
		output cpu_en, output recover);
endinterface

// >>> logic/pscl_doze_div.sv
// cpu clock-enable divider for doze mode
// assumes the peripheral clock is the module clock and never gated here
module pscl_doze_div
	import pscl_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rstn_in,
	pscl_doze_if.div  dz
);

	typedef struct packed {
		logic [6:0] cnt;
		logic       cpu_en;
		logic       recover;
	} pscl_dz_s;

	pscl_dz_s d_r;
	pscl_dz_s d_nxt;
	logic     dozing;

	function automatic logic [6:0] ratio_mask(input logic [2:0] r);
		logic [7:0] m;
		m = (8'h01 << r) - 8'h01;
		return m[6:0];
	endfunction

	assign dozing = dz.doze_en & dz.run;

	always_comb begin
		d_nxt = d_r;
		// phase counter on the peripheral clock runs only while dozing in Run and clears to zero otherwise
		d_nxt.cnt = dozing ? d_r.cnt + 7'h01 : 7'h00;
		// only the cpu enable is divided, peripherals keep every edge
		d_nxt.cpu_en = dz.run & (~dozing | ((d_nxt.cnt & ratio_mask(dz.ratio)) == 7'h00));
		d_nxt.recover = dz.doze_en & dz.rec_on_irq & dz.irq;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			d_r <= '0;
		end else begin
			d_r <= d_nxt;
		end
	end

	assign dz.cpu_en  = d_r.cpu_en;
	assign dz.recover = d_r.recover;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_full_speed_cpu: assert property (dz.run && !dz.doze_en |=> dz.cpu_en)
		else $error("cpu enable dropped outside doze");
	sequence s_doze_steady;
		dz.run && dz.doze_en && $stable(dz.ratio);
	endsequence
	// the enable seen now was decided a cycle ago, so that cycle must be dozing too
	sequence s_cpu_tick;
		$past(dz.run && dz.doze_en) && dz.ratio != 3'h0 && dz.cpu_en;
	endsequence

	a_doze_ratio_gap: assert property ((s_doze_steady and s_cpu_tick) ##1 s_doze_steady
		|-> !dz.cpu_en)
		else $error("cpu enable not divided in doze");
	a_irq_recover: assert property (dz.doze_en && dz.rec_on_irq && dz.irq |=> dz.recover)
		else $error("interrupt did not end doze");
	a_no_recover_hold: assert property (!dz.rec_on_irq |=> !dz.recover)
		else $error("doze ended without recover bit");

endmodule

// >>> testbench/tb_pscl_top.sv
// self-checking bench for the power-saving control block
// assumes pscl_pkg compiled first; drives every port itself, the registers over AXI4-Lite
module tb_pscl_top
	import pscl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  clk_in, rstn_in;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic                  s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic                  s_axi_arvalid_in, s_axi_rready_in;
	logic [31:0]           s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0]            s_axi_wstrb_in;
	logic                  s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic                  s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0]            s_axi_bresp_out, s_axi_rresp_out;
	logic                  sleep_cmd_in, deep_sleep_sel_in, idle_in, wake_event_in, irq_in;
	logic                  wake_sense_pin_in, low_voltage_regulator_fuse_in;
	logic                  discharge_sink_out, discharge_wake_irq_flag_out, main_reg_full_out;
	logic                  main_reg_standby_out, lowv_reg_enable_out, lowv_reg_supply_out;
	logic                  core_ready_out, cpu_clk_en_out;
	int                    n_fail, cmp_count, cyc, lat[6], cnt;
	logic [31:0]           rd;
	logic [1:0]            rsp;
	logic [3:0]            reg_exp[6];
	logic [31:0]           rc_word[6];
	logic                  fuse_v[6];
	int                    fig[6];

	pscl_top i_pscl_top (.clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
		.s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .sleep_cmd_in,
		.deep_sleep_sel_in, .idle_in, .wake_event_in, .irq_in, .wake_sense_pin_in,
		.low_voltage_regulator_fuse_in, .discharge_sink_out, .discharge_wake_irq_flag_out,
		.main_reg_full_out, .main_reg_standby_out, .lowv_reg_enable_out,
		.lowv_reg_supply_out, .core_ready_out, .cpu_clk_en_out);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= 4'hf;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_in);
			if (s_axi_awready_out === 1'b1 && !aw_ok) begin
				aw_ok = 1'b1;
				s_axi_awvalid_in <= 1'b0;
			end
			if (s_axi_wready_out === 1'b1 && !w_ok) begin
				w_ok = 1'b1;
				s_axi_wvalid_in <= 1'b0;
			end
		end
		do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
		rsp = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 1'b0;
		while (s_axi_rvalid_out !== 1'b1) @(posedge clk_in);
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
	endtask

	task automatic pulse_sleep(input logic deep);
		@(posedge clk_in);
		sleep_cmd_in <= 1'b1;
		deep_sleep_sel_in <= deep;
		@(posedge clk_in);
		sleep_cmd_in <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask

	// cycles from a wake event until the core is back in Run
	task automatic wake_wait(output int n);
		@(posedge clk_in);
		wake_event_in <= 1'b1;
		@(posedge clk_in);
		wake_event_in <= 1'b0;
		n = 1;
		while (core_ready_out !== 1'b1 && n < 3000) begin
			@(posedge clk_in);
			n++;
		end
	endtask

	initial begin
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
		{s_axi_arvalid_in, s_axi_rready_in, sleep_cmd_in, deep_sleep_sel_in} = '0;
		{idle_in, wake_event_in, irq_in, low_voltage_regulator_fuse_in} = '0;
		wake_sense_pin_in = 1'b1;
		rstn_in = 1'b0;
		reg_exp = '{4'b1000, 4'b0100, 4'b0011, 4'b0100, 4'b1000, 4'b0000};
		rc_word = '{32'h0000_0100, 32'h0, 32'h0000_1000, 32'h0000_1000, 32'h0000_1100, 32'h0};
		fuse_v = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		fig = '{FAST_WAKE_CYC, STBY_WAKE_CYC, LOWV_WAKE_CYC, STBY_WAKE_CYC, FAST_WAKE_CYC,
			DEEP_WAKE_CYC};
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (int a = 0; a < 12; a += 4) begin
			axi_rd(a[7:0], rd, rsp);
			chk("reset value", 32'h0, rd);
		end
		axi_wr(ADDR_WAKE_CTRL, 32'hffff_ffff);
		chk("mapped bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
		axi_rd(ADDR_WAKE_CTRL, rd, rsp);
		chk("wake ctrl bits", 32'h0000_a100, rd);
		axi_rd(8'h40, rd, rsp);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		chk("unmapped data", 32'h0, rd);
		axi_wr(8'h40, 32'hffff_ffff);
		chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		for (int n = 0; n < 8; n++) begin
			axi_wr(ADDR_CLK_DIV, (n << 12) | 32'h0800);
			repeat (8) @(posedge clk_in);
			cnt = 0;
			repeat (256) begin
				@(posedge clk_in);
				cnt += (cpu_clk_en_out === 1'b1);
			end
			chk("doze ratio count", 256 >> n, cnt);
		end
		axi_wr(ADDR_CLK_DIV, 32'h0000_7000);
		repeat (4) @(posedge clk_in);
		cnt = 0;
		repeat (64) begin
			@(posedge clk_in);
			cnt += (cpu_clk_en_out === 1'b1);
		end
		chk("doze off count", 64, cnt);
		// recovery on interrupt, then the same interrupt with recovery off
		for (int k = 0; k < 2; k++) begin
			axi_wr(ADDR_CLK_DIV, k == 0 ? 32'h0000_b800 : 32'h0000_3800);
			@(posedge clk_in);
			irq_in <= 1'b1;
			@(posedge clk_in);
			irq_in <= 1'b0;
			repeat (5) @(posedge clk_in);
			axi_rd(ADDR_CLK_DIV, rd, rsp);
			chk("clock div after irq", k == 0 ? 32'h0000_b000 : 32'h0000_3800, rd);
		end
		axi_wr(ADDR_CLK_DIV, 32'h0);
		axi_wr(ADDR_WAKE_CTRL, 32'h0);
		for (int m = 0; m < 6; m++) begin
			low_voltage_regulator_fuse_in <= fuse_v[m];
			axi_wr(ADDR_RESET_CTRL, rc_word[m]);
			chk("run regulators", 2'b10, {main_reg_full_out, lowv_reg_supply_out});
			pulse_sleep(m == 5);
			chk("sleep regulators", reg_exp[m], {main_reg_full_out, main_reg_standby_out,
				lowv_reg_enable_out, lowv_reg_supply_out});
			wake_wait(lat[m]);
			chk("wake latency low", 1, lat[m] >= fig[m] - 1);
			chk("wake latency high", 1, lat[m] <= fig[m] + 5);
		end
		chk("latency order", 1, lat[0] < lat[1] && lat[1] < lat[2] && lat[2] < lat[5]);
		low_voltage_regulator_fuse_in <= 1'b0;
		axi_wr(ADDR_RESET_CTRL, 32'h0000_0100);
		axi_wr(ADDR_STATUS, 32'h1);
		axi_wr(ADDR_WAKE_CTRL, 32'h0000_8100);
		chk("sink on", 1, discharge_sink_out);
		pulse_sleep(1'b0);
		wake_sense_pin_in <= 1'b0;
		cnt = 0;
		while (core_ready_out !== 1'b1 && cnt < 200) begin
			@(posedge clk_in);
			cnt++;
		end
		chk("pin wake", 1, core_ready_out);
		chk("wake flag", 1, discharge_wake_irq_flag_out);
		axi_rd(ADDR_STATUS, rd, rsp);
		chk("status word", (32'h1 << ST_FLAG_BIT) | (32'h1 << ST_READY_BIT), rd);
		axi_wr(ADDR_STATUS, 32'h1);
		chk("flag cleared", 0, discharge_wake_irq_flag_out);
		// idle-stopped detector must not trip even with the pin low
		wake_sense_pin_in <= 1'b1;
		axi_wr(ADDR_WAKE_CTRL, 32'h0000_a100);
		idle_in <= 1'b1;
		pulse_sleep(1'b0);
		wake_sense_pin_in <= 1'b0;
		repeat (100) @(posedge clk_in);
		chk("idle stop no wake", 0, {core_ready_out, discharge_wake_irq_flag_out});
		wake_wait(cnt);
		idle_in <= 1'b0;
		axi_wr(ADDR_WAKE_CTRL, 32'h0000_8000);
		chk("sink off", 0, discharge_sink_out);
		conclude();
	end
endmodule
